// ### hw/pirm_peak_interval_rate_monitor.sv
// Purpose: Detect peaks in converter samples and classify peak-to-peak interval
// Assumes: sample_valid_in marks one new sample per cycle it is high
// Notes:   Peak pulse is one clock wide; flags hold until the next peak or timeout
//
// Overview of operation
// RULE1: Compare each new sample with stored sample; keep a copy for next compare.
// RULE2: New sample above stored one means rising; store the new sample.
// RULE3: Equal samples mean constant signal; never declare a peak then.
// RULE4: Declare a peak only when a sample falls after a rising state.
// RULE5: After a peak, keep comparing samples to find the next peak.
// RULE6: Ignore peaks whose amplitude does not exceed the amplitude threshold.
// RULE7: Pulse the peak output once per valid peak.
// RULE8: Time interval between consecutive peaks against lower and upper limits.
// RULE9: Interval above upper limit drives the low-rate flag high.
// RULE10: Interval below lower limit drives the high-rate flag high.
// RULE11: Normal flag high only when interval lies between the limits.
// RULE12: One analog sample input and exactly four digital outputs.
// RULE13: Lower limit 500 ms, upper limit 897 ms by default.
// RULE14: Amplitude threshold 200 mV by default.
// RULE15: Flags captured at peak pulse; interval counter cleared after it.
// RULE16: Counter passing 2.35 s without a peak forces all flags low.
// RULE17: At most one flag high; all low after reset until first interval.
// RULE18: Interval equal to either limit counts as normal.
`timescale 1ns/10ps
`default_nettype none
module pirm_peak_interval_rate_monitor #(
	parameter int unsigned      SAMPLE_W   = pirm_pkg::SAMPLE_W,
	parameter longint unsigned  LOWER_CYC  = pirm_pkg::LOWER_CYC,  // see RULE13
	parameter longint unsigned  UPPER_CYC  = pirm_pkg::UPPER_CYC,  // see RULE13
	parameter longint unsigned  RANGE_CYC  = pirm_pkg::RANGE_CYC,
	parameter longint unsigned  AMP_CODE   = pirm_pkg::AMP_CODE    // see RULE14
) (
	// One sample input and four outputs; see RULE12
	input  wire logic                core_clk_in,
	input  wire logic                rst_n_in,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	input  wire logic                sample_valid_in,
	output var  logic                peak_pulse_out,
	output var  logic                rate_above_limit_flag_out,
	output var  logic                normal_rate_flag_out,
	output var  logic                rate_below_limit_flag_out
);

	// Counter holds one value past the range, so it saturates without wrapping
	localparam int unsigned CNT_W = $clog2(RANGE_CYC + 2);

	////////////////////////////////////////////////////////////////////////////
	// Parameter checks

	if (SAMPLE_W < 2) begin : g_bad_width
		$error("pirm: sample width below two bits");
	end

	if (LOWER_CYC == 0) begin : g_bad_lower
		$error("pirm: lower limit must be above zero");
	end

	if (LOWER_CYC > UPPER_CYC) begin : g_bad_order
		$error("pirm: lower limit above upper limit");
	end

	if (UPPER_CYC >= RANGE_CYC) begin : g_bad_range
		$error("pirm: upper limit not inside counter range");
	end

	if (AMP_CODE >= (64'h1 << SAMPLE_W)) begin : g_bad_amp
		$error("pirm: amplitude threshold beyond sample range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Peak detection

	logic [SAMPLE_W-1:0]   stored_sample;
	pirm_pkg::pirm_trend_t trend;
	pirm_pkg::pirm_trend_t next_trend;
	wire                   is_rising;
	wire                   is_equal;
	wire                   is_falling;
	wire                   trend_hold;
	wire                   was_rising;
	wire                   above_amp;
	wire                   peak_found;

	assign is_rising  = sample_valid_in && (sample_in > stored_sample);                 // see RULE1 see RULE2
	assign is_equal   = sample_valid_in && (sample_in == stored_sample);                // see RULE3
	assign is_falling = sample_valid_in && (sample_in < stored_sample);                 // see RULE4
	// Equal samples and idle cycles keep the trend so a flat top still ends in a peak
	assign trend_hold = is_equal || !sample_valid_in;                                   // see RULE3
	assign was_rising = (trend == pirm_pkg::PIRM_RISING);
	// Amplitude is judged on the stored maximum, the true peak value
	assign above_amp  = stored_sample > AMP_CODE[SAMPLE_W-1:0];                         // see RULE6
	assign peak_found = is_falling && was_rising && above_amp;                          // see RULE4
	assign next_trend = trend_hold ? trend : (is_rising ? pirm_pkg::PIRM_RISING : pirm_pkg::PIRM_IDLE); // see RULE5

	// Falling samples are stored too, so each compare is between neighbours
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stored_sample <= pirm_pkg::SAMPLE_RST;
		end else if (sample_valid_in) begin
			stored_sample <= sample_in;                                                 // see RULE1 see RULE2
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trend <= pirm_pkg::PIRM_IDLE;
		end else begin
			trend <= next_trend;                                                        // see RULE5
		end
	end

	// Registered pulse costs one cycle of latency but keeps the pin glitch free
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			peak_pulse_out <= 1'h0;
		end else begin
			peak_pulse_out <= peak_found;                                               // see RULE7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interval measurement

	logic [CNT_W-1:0] interval_counter;
	logic [CNT_W-1:0] next_interval_counter;
	logic             first_seen;
	logic             timed_out;
	wire              below_lower;
	wire              above_upper;
	wire              cnt_over;
	wire              timeout_edge;

	assign below_lower = interval_counter < LOWER_CYC[CNT_W-1:0];                       // see RULE10
	assign above_upper = interval_counter > UPPER_CYC[CNT_W-1:0];                       // see RULE9
	assign cnt_over    = interval_counter > RANGE_CYC[CNT_W-1:0];                       // see RULE16
	assign timeout_edge = cnt_over && !timed_out;

	// Counter saturates past the range so a long gap cannot wrap into a valid interval
	assign next_interval_counter = peak_pulse_out ? '0 :                                // see RULE15
		(cnt_over ? interval_counter : interval_counter + 1'h1);                        // see RULE8

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interval_counter <= '0;
		end else begin
			interval_counter <= next_interval_counter;                                  // see RULE8
		end
	end

	// First peak after reset only starts timing
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			first_seen <= 1'h0;                                                         // see RULE17
		end else if (peak_found) begin
			first_seen <= 1'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timed_out <= 1'h0;
		end else begin
			timed_out <= cnt_over;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rate classification

	wire flag_load;
	wire flag_clear;
	wire next_above;
	wire next_normal;
	wire next_below;

	// Load and clear exclude each other: load needs the counter inside its range
	assign flag_load   = peak_found && first_seen && !cnt_over;                         // see RULE15 see RULE17
	assign flag_clear  = (timeout_edge && !peak_found) || (peak_found && cnt_over);     // see RULE16
	assign next_above  = below_lower;                                                   // see RULE10
	assign next_normal = !below_lower && !above_upper;                                  // see RULE11 see RULE18
	assign next_below  = above_upper;                                                   // see RULE9

	pirm_flag_reg u_high_rate_capture (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (flag_load),
		.clear_in    (flag_clear),
		.next_in     (next_above),
		.flag_out    (rate_above_limit_flag_out)
	);

	pirm_flag_reg u_normal_rate_capture (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (flag_load),
		.clear_in    (flag_clear),
		.next_in     (next_normal),
		.flag_out    (normal_rate_flag_out)
	);

	pirm_flag_reg u_low_rate_capture (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (flag_load),
		.clear_in    (flag_clear),
		.next_in     (next_below),
		.flag_out    (rate_below_limit_flag_out)
	);

endmodule

////////////////////////////////////////////////////////////////////////////////
// One rate flag: clear wins over load, holds otherwise

module pirm_flag_reg (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic load_in,
	input  wire logic clear_in,
	input  wire logic next_in,
	output var  logic flag_out
);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= 1'h0;                                                           // see RULE17
		end else if (clear_in) begin
			flag_out <= 1'h0;                                                           // see RULE16
		end else if (load_in) begin
			flag_out <= next_in;                                                        // see RULE15
		end
	end

endmodule
`default_nettype wire

// ### hw/pirm_pkg.sv
// Purpose: Shared constants for the peak interval rate monitor
// Assumes: 125 MHz core clock, one converter sample per strobe
// Notes:   Times are kept in their printed units; cycle counts derive from them
package pirm_pkg;
	localparam int unsigned CLK_HZ          = 125000000;
	localparam int unsigned SAMPLE_W        = 8;
	localparam int unsigned LOWER_MS        = 500;
	localparam int unsigned UPPER_MS        = 897;
	localparam int unsigned RANGE_MS        = 2350;
	localparam int unsigned AMP_THRESH_MV   = 200;
	localparam int unsigned FULL_SCALE_MV   = 1000;
	localparam longint unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam longint unsigned LOWER_CYC   = LOWER_MS * CYC_PER_MS;
	localparam longint unsigned UPPER_CYC   = UPPER_MS * CYC_PER_MS;
	localparam longint unsigned RANGE_CYC   = RANGE_MS * CYC_PER_MS;
	localparam longint unsigned AMP_CODE    = (AMP_THRESH_MV * 256) / FULL_SCALE_MV;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 8'h00;
	typedef enum logic [1:0] {
		PIRM_IDLE,
		PIRM_RISING
	} pirm_trend_t;
endpackage

// ### verification/pirm_checker.sv
// Purpose: Port assertions for the rate monitor
// Assumes: Stored sample is rebuilt from the ports
// Notes:   Timeout bound carries one cycle of slack
`timescale 1ns/10ps
`default_nettype none
module pirm_checker #(
	parameter longint unsigned RANGE_CYC = 235,
	parameter longint unsigned AMP_CODE  = 51
) (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic       sample_valid_in,
	input wire logic [7:0] sample_in,
	input wire logic       peak_pulse_out,
	input wire logic       rate_above_limit_flag_out,
	input wire logic       normal_rate_flag_out,
	input wire logic       rate_below_limit_flag_out
);
	logic [7:0]  last;
	wire         fell = sample_valid_in && (sample_in < last);
	int unsigned cnt;
	wire  [2:0]  flags = {rate_above_limit_flag_out, normal_rate_flag_out, rate_below_limit_flag_out};
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last <= 8'h00;
			cnt <= 0;
		end else begin
			if (sample_valid_in) last <= sample_in;
			cnt <= peak_pulse_out ? 0 : cnt + 1;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_flags_onehot: assert property ($onehot0(flags)) else $error("two rate flags high");
	a_pulse_single: assert property (peak_pulse_out |=> !peak_pulse_out) else $error("peak pulse too long");
	a_peak_on_fall: assert property (peak_pulse_out |-> $past(fell))
		else $error("peak without falling sample");
	a_equal_no_peak: assert property (sample_valid_in && sample_in == last |=> !peak_pulse_out)
		else $error("peak on equal samples");
	a_rise_no_peak: assert property (sample_valid_in && sample_in > last |=> !peak_pulse_out)
		else $error("peak on rising sample");
	a_small_no_peak: assert property (sample_valid_in && last <= AMP_CODE |=> !peak_pulse_out)
		else $error("peak below amplitude threshold");
	a_flags_steady: assert property ($changed(flags) |-> peak_pulse_out || flags == 3'h0)
		else $error("flags moved without peak");
	a_timeout_clear: assert property (cnt > RANGE_CYC + 2 |-> flags == 3'h0)
		else $error("flags kept after timeout");
endmodule
bind pirm_peak_interval_rate_monitor pirm_checker #(.RANGE_CYC(RANGE_CYC), .AMP_CODE(AMP_CODE)) u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sample_valid_in(sample_valid_in), .sample_in(sample_in),
	.peak_pulse_out(peak_pulse_out), .rate_above_limit_flag_out(rate_above_limit_flag_out),
	.normal_rate_flag_out(normal_rate_flag_out), .rate_below_limit_flag_out(rate_below_limit_flag_out));
`default_nettype wire

// ### verification/pirm_peak_interval_rate_monitor_tb.sv
// Purpose: Self-checking bench for the rate monitor
// Assumes: Limits shortened to 50, 90 and 235 cycles
// Notes:   Intervals keep clear of the limits since sample cadence adds jitter
`timescale 1ns/10ps
`default_nettype none
module pirm_peak_interval_rate_monitor_tb;
	logic       core_clk_in = 1'b0;
	logic       rst_n_in    = 1'b0;
	logic [7:0] level       = 8'h10;
	logic [7:0] smp;
	logic       vld, pls, fa, fn, fb;
	int         n_mismatch = 0, n_compared = 0, n_pulse = 0;
	initial forever #4 core_clk_in = ~core_clk_in;
	pirm_sensor_model sensor (.core_clk_in(core_clk_in), .level_in(level), .sample_out(smp), .valid_out(vld));
	pirm_peak_interval_rate_monitor #(.LOWER_CYC(50), .UPPER_CYC(90), .RANGE_CYC(235)) dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sample_in(smp), .sample_valid_in(vld),
		.peak_pulse_out(pls), .rate_above_limit_flag_out(fa), .normal_rate_flag_out(fn),
		.rate_below_limit_flag_out(fb));
	always @(posedge core_clk_in) if (pls === 1'b1) n_pulse++;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task idle(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask
	// Flat top held four cycles: equal samples must not split one peak in two
	task pk(input logic [7:0] h, input int gap);
		idle(gap);
		level <= h;
		idle(4);
		level <= 8'h10;
		idle(6);
	endtask
	task rate(input int gap, input logic [7:0] exp);
		pk(8'hC0, gap);
		chk({5'h00, fa, fn, fb}, exp);
	endtask
	task t_first;
		pk(8'h20, 4);
		chk(n_pulse[7:0], 8'h00);
		pk(8'hC0, 4);
		chk(n_pulse[7:0], 8'h01);
		chk({5'h00, fa, fn, fb}, 8'h00);
		$display("first peak test done");
	endtask
	task t_rates;
		rate(20, 8'h04);
		rate(60, 8'h02);
		rate(140, 8'h01);
		chk(n_pulse[7:0], 8'h04);
		$display("rate test done");
	endtask
	task t_timeout;
		idle(300);
		chk({5'h00, fa, fn, fb}, 8'h00);
		rate(10, 8'h00);
		rate(60, 8'h02);
		$display("timeout test done");
	endtask
	initial begin
		idle(20);
		rst_n_in <= 1'b1;
		t_first;
		t_rates;
		t_timeout;
		conclude;
	end
	initial begin
		idle(3000);
		n_mismatch++;
		conclude;
	end
endmodule
`default_nettype wire

// ### verification/pirm_sensor_model.sv
// Purpose: Converter model feeding the rate monitor
// Assumes: One sample every other clock
// Notes:   Bus toggles between samples so stale data is never mistaken for a sample
`timescale 1ns/10ps
`default_nettype none
module pirm_sensor_model (
	input  wire logic       core_clk_in,
	input  wire logic [7:0] level_in,
	output var  logic [7:0] sample_out,
	output var  logic       valid_out
);
	initial begin
		sample_out = 8'h00;
		valid_out = 1'b0;
	end
	always @(posedge core_clk_in) begin
		valid_out <= !valid_out;
		sample_out <= valid_out ? ~sample_out : level_in;
	end
endmodule
`default_nettype wire
